// >>> design/vbi_fifo_defines.svh
// Purpose: Register offsets, reset values, field positions and sizes of the blanking-data FIFO.
// Assumes: Included by the FIFO status module; the package does not include it.
// Notes: The header holds definitions only.
// How it works
// RULE1: Reading any register leaves every slicer status flag unchanged.
// RULE2: A sticky status flag clears only when written with one.
// RULE3: Status bit 6 shows live FIFO emptiness without any host write.
// RULE4: Status bit 7 sets when a whole line cannot fit the space left.
// RULE5: A line that does not fit stores none of its bytes.
// RULE6: A later line that fits is stored even while bit 7 stays set.
// RULE7: Status bits 5 to 0 flag new captured data per service.
// RULE8: The word-count register shows stored words, two bytes each.
// RULE9: Threshold condition is word count above threshold, which resets to 128.
// RULE10: Host enables the threshold source before it reaches the interrupt pin; the code has no enable and drives thresholdEvent_q directly.
// RULE11: Any write to the flush register empties the FIFO at once.
// RULE12: The flush write also clears all captured-data read registers.
// RULE13: Host loads slicer configuration constants; two custom slots stay free. The code decodes no configuration register.
// RULE14: Crossing the threshold raises the threshold interrupt status event.
// RULE15: Output control bit picks host register drain or ancillary bus drain.
// RULE16: Word count grows by committed lines and drops as bytes drain.
`ifndef VBI_FIFO_DEFINES_SVH
`define VBI_FIFO_DEFINES_SVH
`define REG_FIFO_DATA 8'hB0
`define REG_SLICER_STATUS 8'hC6
`define REG_FIFO_WORD_COUNT 8'hC7
`define REG_FIFO_IRQ_THRESHOLD 8'hC8
`define REG_FIFO_FLUSH 8'hC9
`define REG_OUT_CTRL 8'hCD
`define THRESHOLD_RESET 8'h80
`define OUT_CTRL_RESET 1'b1
`define ST_OVERFLOW 7
`define ST_EMPTY 6
`define FIFO_BYTES 10'h1FE
`define MEM_DEPTH 512
`endif

// >>> design/vbi_fifo_pkg.sv
// Purpose: Types shared by the blanking-data FIFO status logic.
// Assumes: Constants stay in the defines header; this package does not include it and uses literal widths.
// Notes: Structs carry the register request and the slicer line stream.
package vbi_fifo_pkg;
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } regReq_t;
  typedef struct packed {
    logic start;
    logic [9:0] len;
    logic valid;
    logic [7:0] data;
    logic done;
  } lineIn_t;
  typedef enum logic [1:0] {
    LINE_IDLE = 2'b00,
    LINE_TAKE = 2'b01,
    LINE_DROP = 2'b10
  } lineState_t;
endpackage

// >>> design/vbi_data_fifo_status.sv
// Purpose: Blanking-data FIFO with status flags, word count, threshold event and flush.
// Assumes: Register accesses arrive already decoded from the serial control port.
// Notes: A line is checked for room once, at its start, and committed at its end.
`timescale 1ns/1ps
`include "vbi_fifo_defines.svh"
module vbi_data_fifo_status (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register access
  input wire vbi_fifo_pkg::regReq_t regReq,
  output logic [7:0] regRdata_q,
  // Slicer side
  input wire vbi_fifo_pkg::lineIn_t lineIn,
  input wire logic [5:0] svcCaptured,
  // Ancillary output
  output logic ancValid_q,
  output logic [7:0] ancData_q,
  input wire logic ancReady,
  // Side effects
  output logic thresholdEvent_q,
  output logic readRegsClear_q,
  output logic hostAccess_q
);
  import vbi_fifo_pkg::*;

  logic [7:0] mem [0:`MEM_DEPTH-1];
  logic [8:0] wrPtr_q;
  logic [8:0] rdPtr_q;
  logic [9:0] committed_q;
  logic [9:0] pending_q;
  logic [9:0] lineLen_q;
  logic [1:0] bufCnt_q;
  logic [7:0] buf0_q;
  logic [7:0] buf1_q;
  logic [7:0] status_q;
  logic [7:0] threshold_q;
  logic thrAbove_q;
  lineState_t state_q;
  lineState_t state_d;
  logic [7:0] buf0_d;
  logic [7:0] buf1_d;

  wire wrStatus = regReq.write && (regReq.addr == `REG_SLICER_STATUS);
  wire wrThreshold = regReq.write && (regReq.addr == `REG_FIFO_IRQ_THRESHOLD);
  wire wrOutCtrl = regReq.write && (regReq.addr == `REG_OUT_CTRL);
  // RULE11 flush decode
  wire flush = regReq.write && (regReq.addr == `REG_FIFO_FLUSH);
  wire [9:0] freeBytes = `FIFO_BYTES - committed_q - pending_q;
  wire lineFits = lineIn.len <= freeBytes;
  wire startIdle = lineIn.start && (state_q == LINE_IDLE) && !flush;
  // RULE6 fit check ignores status
  wire lineAccept = startIdle && lineFits;
  // RULE4 whole-line fit
  wire lineReject = startIdle && !lineFits;
  // RULE5 store only accepted
  wire byteStore = (state_q == LINE_TAKE) && lineIn.valid && !flush && (pending_q < lineLen_q);
  wire lineCommit = (state_q == LINE_TAKE) && lineIn.done && !flush;
  // RULE8 words from bytes
  wire [7:0] wordCount = committed_q[8:1];
  wire fifoEmpty = committed_q == 10'h000;
  // RULE15 drain path select
  wire hostPop = regReq.read && (regReq.addr == `REG_FIFO_DATA) && hostAccess_q && (bufCnt_q != 2'h0);
  wire ancPop = ancValid_q && ancReady && !hostAccess_q;
  wire outPop = hostPop || ancPop;
  wire [9:0] memAvail = committed_q - {8'h00, bufCnt_q};
  wire bufLoad = (memAvail != 10'h000) && ((bufCnt_q != 2'h2) || outPop) && !flush;
  wire [7:0] memOut = mem[rdPtr_q];
  wire [1:0] bufCnt_d = flush ? 2'h0 : bufCnt_q + {1'b0, bufLoad} - {1'b0, outPop};
  wire hostAccess_d = wrOutCtrl ? regReq.wdata[0] : hostAccess_q;
  // RULE16 count follows commits and drains
  wire [9:0] committed_d = flush ? 10'h000 :
    committed_q + (lineCommit ? pending_q : 10'h000) - {9'h000, outPop};
  // RULE2 write one clears
  wire [7:0] clearMask = wrStatus ? regReq.wdata : 8'h00;
  // RULE7 per-service flags
  wire [7:0] setMask = {lineReject, 1'b0, svcCaptured};
  wire [7:0] status_d = ((status_q & ~clearMask) | setMask) & ~(8'h01 << `ST_EMPTY);
  // RULE9 threshold compare
  wire thrAbove = wordCount > threshold_q;
  // RULE3 live empty bit
  wire [7:0] statusView = status_q | ({7'h00, fifoEmpty} << `ST_EMPTY);
  // RULE1 reads have no side effect on the status flags
  wire [7:0] rdMux =
    (regReq.addr == `REG_SLICER_STATUS) ? statusView :
    (regReq.addr == `REG_FIFO_WORD_COUNT) ? wordCount :
    (regReq.addr == `REG_FIFO_IRQ_THRESHOLD) ? threshold_q :
    (regReq.addr == `REG_OUT_CTRL) ? {7'h00, hostAccess_q} :
    (hostPop) ? buf0_q : 8'h00;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LINE_IDLE: begin
        if (lineIn.start) begin
          state_d = lineAccept ? LINE_TAKE : LINE_DROP;
        end
      end
      LINE_TAKE: begin
        if (lineIn.done) begin
          state_d = LINE_IDLE;
        end else if (flush) begin
          state_d = LINE_DROP;
        end
      end
      LINE_DROP: begin
        if (lineIn.done) begin
          state_d = LINE_IDLE;
        end
      end
      default: state_d = LINE_IDLE;
    endcase
  end

  // The two-entry buffer keeps the drain side decoupled, so a stall loses no byte.
  always_comb begin
    buf0_d = buf0_q;
    buf1_d = buf1_q;
    if (outPop) begin
      if (bufCnt_q == 2'h2) begin
        buf0_d = buf1_q;
        if (bufLoad) begin
          buf1_d = memOut;
        end
      end else if (bufLoad) begin
        buf0_d = memOut;
      end
    end else if (bufLoad) begin
      if (bufCnt_q == 2'h0) begin
        buf0_d = memOut;
      end else begin
        buf1_d = memOut;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (byteStore) begin
      mem[wrPtr_q] <= lineIn.data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= 9'h000;
      rdPtr_q <= 9'h000;
      pending_q <= 10'h000;
      lineLen_q <= 10'h000;
      committed_q <= 10'h000;
      state_q <= LINE_IDLE;
    end else begin
      wrPtr_q <= flush ? 9'h000 : wrPtr_q + {8'h00, byteStore};
      rdPtr_q <= flush ? 9'h000 : rdPtr_q + {8'h00, bufLoad};
      pending_q <= (flush || lineCommit) ? 10'h000 : pending_q + {9'h000, byteStore};
      lineLen_q <= lineAccept ? lineIn.len : lineLen_q;
      committed_q <= committed_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bufCnt_q <= 2'h0;
      buf0_q <= 8'h00;
      buf1_q <= 8'h00;
      ancValid_q <= 1'b0;
      ancData_q <= 8'h00;
      hostAccess_q <= `OUT_CTRL_RESET;
    end else begin
      bufCnt_q <= bufCnt_d;
      buf0_q <= buf0_d;
      buf1_q <= buf1_d;
      ancValid_q <= (bufCnt_d != 2'h0) && !hostAccess_d;
      ancData_q <= buf0_d;
      hostAccess_q <= hostAccess_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 8'h00;
      threshold_q <= `THRESHOLD_RESET;
      thrAbove_q <= 1'b0;
      thresholdEvent_q <= 1'b0;
      readRegsClear_q <= 1'b0;
      regRdata_q <= 8'h00;
    end else begin
      status_q <= status_d;
      threshold_q <= wrThreshold ? regReq.wdata : threshold_q;
      thrAbove_q <= thrAbove;
      // RULE14 crossing event
      thresholdEvent_q <= thrAbove && !thrAbove_q;
      // RULE12 clear captured registers
      readRegsClear_q <= flush;
      regRdata_q <= regReq.read ? rdMux : regRdata_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_read_keeps_flags: assert property ( // RULE1
    (!regReq.write && svcCaptured == 6'h00 && !lineReject) |=> status_q == $past(status_q))
    else $error("Status flags changed without a set or a clear.");
  chk_clear_by_one: assert property ( // RULE2
    (wrStatus && svcCaptured == 6'h00 && !lineReject) |=>
      ((status_q & $past(regReq.wdata)) == 8'h00) && ((status_q & ~$past(regReq.wdata)) ==
      ($past(status_q) & ~$past(regReq.wdata))))
    else $error("Write-one clear misbehaved.");
  chk_empty_live: assert property ( // RULE3
    (regReq.read && regReq.addr == `REG_SLICER_STATUS) |=>
      regRdata_q[`ST_EMPTY] == $past(fifoEmpty))
    else $error("Empty bit does not follow FIFO occupancy.");
  chk_overflow_flag: assert property ( // RULE4
    lineReject |=> status_q[`ST_OVERFLOW] && state_q == LINE_DROP)
    else $error("Rejected line did not raise overflow.");
  chk_drop_stores_none: assert property ( // RULE5
    (state_q == LINE_DROP && !flush) |=> $stable(wrPtr_q))
    else $error("Byte stored from a dropped line.");
  chk_fit_after_error: assert property ( // RULE6
    lineAccept |=> state_q == LINE_TAKE && pending_q == 10'h000)
    else $error("Fitting line was not taken.");
  chk_word_count: assert property ( // RULE8
    (regReq.read && regReq.addr == `REG_FIFO_WORD_COUNT) |=>
      regRdata_q == $past(committed_q[8:1]))
    else $error("Word count does not match stored bytes.");
  chk_threshold_event: assert property ( // RULE14
    (thrAbove && !thrAbove_q) |=> thresholdEvent_q ##1 !thresholdEvent_q)
    else $error("Threshold crossing event missing.");
  chk_flush_empties: assert property ( // RULE11
    flush |=> committed_q == 10'h000 && bufCnt_q == 2'h0 && readRegsClear_q)
    else $error("Flush did not empty the FIFO.");
  chk_commit_count: assert property ( // RULE16
    (lineCommit && !outPop) |=> committed_q == $past(committed_q) + $past(pending_q))
    else $error("Committed line not counted.");
  chk_drain_path: assert property ( // RULE15
    hostAccess_q |-> !ancValid_q)
    else $error("Ancillary output active in host drain mode.");
endmodule

// >>> bench/vbi_host_model.sv
// Purpose: Host model that issues register reads and writes.
// Assumes: Requests change at the falling edge of clk.
// Notes: Each request is a one-cycle pulse, so calls never overlap.
`timescale 1ns/1ps
module vbi_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output vbi_fifo_pkg::regReq_t regReq,
  input wire logic [7:0] regRdata_q
);
  import vbi_fifo_pkg::*;
  initial regReq = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(negedge clk);
    regReq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    regReq <= '0;
    d = regRdata_q;
  endtask
endmodule

// >>> bench/vbi_data_fifo_status_test.sv
// Purpose: Self-checking bench for the blanking-data FIFO status block.
// Assumes: Inputs change at the falling edge of clk.
// Notes: The consumer stalls on purpose so the output buffer must hold bytes.
`timescale 1ns/1ps
module vbi_data_fifo_status_test;
  import vbi_fifo_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  regReq_t regReq;
  lineIn_t lineIn = '0;
  logic [5:0] svcCaptured = '0;
  logic ancReady = 1'b0;
  logic [7:0] regRdata_q, ancData_q, rv;
  logic ancValid_q, thresholdEvent_q, readRegsClear_q, hostAccess_q;
  int bad_count = 0;
  int n_tests = 0;
  int thrHits = 0;
  int clrHits = 0;
  logic [7:0] ancQ[$];
  always #4 clk = ~clk;
  vbi_data_fifo_status u_dut (.clk(clk), .reset_n(reset_n), .regReq(regReq),
    .regRdata_q(regRdata_q), .lineIn(lineIn), .svcCaptured(svcCaptured),
    .ancValid_q(ancValid_q), .ancData_q(ancData_q), .ancReady(ancReady),
    .thresholdEvent_q(thresholdEvent_q), .readRegsClear_q(readRegsClear_q),
    .hostAccess_q(hostAccess_q));
  vbi_host_model u_host (.clk(clk), .regReq(regReq), .regRdata_q(regRdata_q));
  always @(posedge clk) begin
    if (thresholdEvent_q === 1'b1) thrHits++;
    if (readRegsClear_q === 1'b1) clrHits++;
    if (ancValid_q === 1'b1 && ancReady) ancQ.push_back(ancData_q);
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, rv);
    check(rv, exp, $sformatf("reg %h", a));
  endtask
  task automatic send(input int n, input logic [7:0] b);
    @(negedge clk);
    lineIn <= '{1'b1, 10'(n), 1'b0, 8'h00, 1'b0};
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      lineIn <= '{1'b0, 10'(n), 1'b1, 8'(b + i), 1'b0};
    end
    @(negedge clk);
    lineIn <= '{1'b0, 10'(n), 1'b0, 8'h00, 1'b1};
    @(negedge clk);
    lineIn <= '0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim;
  end
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    rchk(8'hC6, 8'h40);
    rchk(8'hC8, 8'h80);
    rchk(8'hC7, 8'h00);
    rchk(8'h55, 8'h00);
    check({7'h0, hostAccess_q}, 8'h01, "host access");
    u_host.wr(8'hC4, 8'h00);
    u_host.wr(8'hC5, 8'h00);
    rchk(8'hC6, 8'h40);
    $display("test reset done");
    send(4, 8'hA0);
    rchk(8'hC7, 8'h02);
    rchk(8'hC6, 8'h00);
    rchk(8'hC6, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rchk(8'hB0, 8'(8'hA0 + i));
      if (i == 1) rchk(8'hC7, 8'h01);
    end
    rchk(8'hC6, 8'h40);
    $display("test host drain done");
    for (int b = 0; b < 6; b++) begin
      @(negedge clk);
      svcCaptured <= 6'(1 << b);
      @(negedge clk);
      svcCaptured <= '0;
      rchk(8'hC6, 8'(8'h40 | (1 << b)));
      u_host.wr(8'hC6, 8'h00);
      rchk(8'hC6, 8'(8'h40 | (1 << b)));
      u_host.wr(8'hC6, 8'(1 << b));
      rchk(8'hC6, 8'h40);
    end
    $display("test service flags done");
    send(254, 8'h00);
    send(254, 8'h00);
    rchk(8'hC7, 8'hFE);
    check(8'(thrHits), 8'h01, "threshold pulses");
    send(4, 8'h00);
    rchk(8'hC6, 8'h80);
    rchk(8'hC7, 8'hFE);
    u_host.wr(8'hC1, 8'h04);
    u_host.wr(8'hC8, 8'hFE);
    send(2, 8'h00);
    rchk(8'hC7, 8'hFF);
    check(8'(thrHits), 8'h02, "threshold pulses");
    $display("test overflow done");
    u_host.wr(8'hC9, 8'h5A);
    rchk(8'hC7, 8'h00);
    rchk(8'hC6, 8'hC0);
    check(8'(clrHits), 8'h01, "clear pulses");
    u_host.wr(8'hC6, 8'h80);
    fork
      send(6, 8'h10);
      begin
        repeat (3) @(negedge clk);
        u_host.wr(8'hC9, 8'h00);
      end
    join
    rchk(8'hC7, 8'h00);
    rchk(8'hC6, 8'h40);
    check(8'(clrHits), 8'h02, "clear pulses");
    $display("test flush done");
    u_host.wr(8'hCD, 8'h00);
    check({7'h0, hostAccess_q}, 8'h00, "host access");
    send(6, 8'hC0);
    rchk(8'hB0, 8'h00);
    repeat (8) @(negedge clk);
    ancReady <= 1'b1;
    repeat (12) @(negedge clk);
    check(8'(ancQ.size()), 8'h06, "anc bytes");
    foreach (ancQ[i]) check(ancQ[i], 8'(8'hC0 + i), "anc order");
    rchk(8'hC7, 8'h00);
    rchk(8'hC6, 8'h40);
    $display("test ancillary done");
    end_sim;
  end
endmodule
